// ### core/cam_defines.svh
/*
 * Shared constants of the addressing-mode core: data-space addresses,
 * opcode field positions, instruction lengths and cycle counts.
 * Assumes inclusion by bare name from the core design files.
 */
`ifndef CAM_DEFINES_SVH
`define CAM_DEFINES_SVH

// Data-space locations and reset value
`define CAM_ADDR_X 8'h80
`define CAM_ADDR_Y 8'h81
`define CAM_ADDR_V 8'h82
`define CAM_ADDR_W 8'h83
`define CAM_ADDR_ACC 8'hFF
`define CAM_MEM_RESET 8'h00

// Opcode field positions
`define CAM_DIR_BIT 4
`define CAM_PTR_BIT 4
`define CAM_SEL_BIT 3

// Instruction lengths in bytes
`define CAM_LEN_ONE 2'h1
`define CAM_LEN_TWO 2'h2
`define CAM_LEN_THREE 2'h3

// Cycle counts per instruction group
`define CAM_CYC_LDST 3'h4
`define CAM_CYC_REL 3'h2
`define CAM_CYC_BTB 3'h5
`define CAM_CYC_BIT 3'h4
`define CAM_CYC_EXT 3'h4
`define CAM_CYC_INH 3'h2

// Program counter and stack
`define CAM_PC_RESET 12'h000
`define CAM_STACK_LEVELS 6

`endif

// ### core/cam_pkg.sv
/*
 * Types of the addressing-mode core: modes, operations, sequencer states.
 * Assumes nothing of its surroundings.
 */
package cam_pkg;

    typedef enum logic [3:0] {
        MODE_IMM, MODE_DIR, MODE_SDIR, MODE_EXT, MODE_REL,
        MODE_BITD, MODE_BTB, MODE_IND, MODE_INH
    } cam_mode_t;

    typedef enum logic [3:0] {
        OP_NOP, OP_RET, OP_JR, OP_LONG_GO, OP_CALL, OP_BIT_WRITE, OP_BTB,
        OP_LOAD, OP_STORE, OP_LOAD_IMM, OP_LOAD_IMM_REG
    } cam_op_t;

    typedef enum logic [2:0] {
        ST_FETCH = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } cam_state_t;

endpackage

// ### core/cam_dec_if.sv
/*
 * Carrier between the sequencer and the opcode decoder.
 * Assumes cam_pkg is compiled first.
 */
`timescale 1ns/1ps
interface cam_dec_if;
    import cam_pkg::*;
    logic [7:0] opcode;
    cam_mode_t mode;
    cam_op_t op;
    logic [1:0] len;
    logic [2:0] cycles;
    logic illegal;

    modport dec (
        input opcode,
        output mode, op, len, cycles, illegal
    );
    modport core (
        output opcode,
        input mode, op, len, cycles, illegal
    );
endinterface

// ### core/cam_opcode_decode.sv
/*
 * Combinational opcode decoder: mode, operation, length, cycle count.
 * Assumes the opcode on the carrier is stable for the cycle it is used.
 */
`timescale 1ns/1ps
`include "cam_defines.svh"
module cam_opcode_decode (
    cam_dec_if.dec dif
);
    import cam_pkg::*;

    always_comb begin
        dif.mode = MODE_INH;
        dif.op = OP_NOP;
        dif.len = `CAM_LEN_ONE;
        dif.cycles = `CAM_CYC_INH;
        dif.illegal = 1'b0;
        case (dif.opcode[7:5])
            3'b000, 3'b001, 3'b010, 3'b011: begin
                dif.mode = MODE_REL;
                dif.op = OP_JR;
                dif.cycles = `CAM_CYC_REL;
            end
            3'b100: begin
                dif.mode = MODE_EXT;
                dif.op = dif.opcode[`CAM_DIR_BIT] ? OP_CALL : OP_LONG_GO;
                dif.len = `CAM_LEN_TWO;
                dif.cycles = `CAM_CYC_EXT;
            end
            3'b101: begin
                if (dif.opcode[4]) begin
                    dif.mode = MODE_BTB;
                    dif.op = OP_BTB;
                    dif.len = `CAM_LEN_THREE;
                    dif.cycles = `CAM_CYC_BTB;
                end else begin
                    dif.mode = MODE_BITD;
                    dif.op = OP_BIT_WRITE;
                    dif.len = `CAM_LEN_TWO;
                    dif.cycles = `CAM_CYC_BIT;
                end
            end
            3'b110: begin
                dif.mode = MODE_SDIR;
                dif.op = dif.opcode[4] ? OP_STORE : OP_LOAD;
                dif.cycles = `CAM_CYC_LDST;
                dif.illegal = dif.opcode[3:2] != 2'h0;
            end
            default: begin
                dif.cycles = `CAM_CYC_LDST;
                dif.op = dif.opcode[0] ? OP_STORE : OP_LOAD;
                case (dif.opcode[3:2])
                    2'h0: begin
                        dif.mode = MODE_IND;
                        dif.illegal = dif.opcode[1];
                    end
                    2'h1: begin
                        if (dif.opcode[4]) begin
                            dif.mode = MODE_IMM;
                            dif.op = dif.opcode[0] ? OP_LOAD_IMM_REG : OP_LOAD_IMM;
                            dif.len = dif.opcode[0] ? `CAM_LEN_THREE : `CAM_LEN_TWO;
                        end else begin
                            dif.mode = MODE_DIR;
                            dif.len = `CAM_LEN_TWO;
                        end
                        dif.illegal = dif.opcode[1];
                    end
                    2'h2: begin
                        dif.mode = MODE_INH;
                        dif.cycles = `CAM_CYC_INH;
                        dif.op = dif.opcode[0] ? OP_RET : OP_NOP;
                        dif.illegal = dif.opcode[1] | dif.opcode[4];
                    end
                    default: begin
                        dif.op = OP_NOP;
                        dif.cycles = `CAM_CYC_INH;
                        dif.illegal = 1'b1;
                    end
                endcase
            end
        endcase
        // Invalid opcodes retire as a one-byte, two-cycle no-op
        if (dif.illegal) begin
            dif.len = `CAM_LEN_ONE;
            dif.cycles = `CAM_CYC_INH;
        end
    end
endmodule

// ### core/cam_core_addr.sv
/*
 * Addressing-mode and load/store core: fetch, operand address forming,
 * branch targets, bit operations, return stack, flags, data space.
 * Assumes opByte/argByte1/argByte2 give the program bytes at progAddr,
 * progAddr+1 and progAddr+2 in the same cycle, synchronous to clk.
 */
`timescale 1ns/1ps
`include "cam_defines.svh"
module cam_core_addr #(
    parameter int STACK_LEVELS = `CAM_STACK_LEVELS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic [7:0] opByte,
    input wire logic [7:0] argByte1,
    input wire logic [7:0] argByte2,
    input wire logic [7:0] peekAddr,
    output logic [11:0] progAddr,
    output logic [7:0] peekData,
    output logic [7:0] accValue,
    output logic zeroFlag,
    output logic carryFlag,
    output logic [2:0] stackDepth,
    output logic instrDone,
    output logic illegalOp,
    output cam_pkg::cam_mode_t modeNow
);
    import cam_pkg::*;

    localparam logic [2:0] SP_LAST = 3'(STACK_LEVELS - 1);
    localparam logic [2:0] SP_FULL = 3'(STACK_LEVELS);

    cam_state_t state_q;
    logic [2:0] cnt_q;
    logic [11:0] pc_q;
    logic [7:0] opcode_q;
    logic [7:0] arg1_q;
    logic [7:0] arg2_q;
    logic zero_q;
    logic carry_q;
    logic [2:0] sp_q;
    logic [2:0] depth_q;
    logic [7:0] peek_q;
    logic [7:0] mem [0:255];
    logic [11:0] stack [0:STACK_LEVELS-1];

    logic stFetch;
    logic stDone;
    logic commit;
    logic [7:0] opAddr;
    logic [7:0] operand;
    logic [7:0] accVal;
    logic [2:0] bitNum;
    logic bitVal;
    logic [7:0] bitMask;
    logic [7:0] bitWritten;
    logic [7:0] newAcc;
    logic relTaken;
    logic [11:0] relTarget;
    logic [11:0] extTarget;
    logic [11:0] btbTarget;
    logic [11:0] nextPc;
    logic [2:0] spNext;
    logic [2:0] spPrev;

    cam_dec_if dif();

    cam_opcode_decode u_dec (
        .dif(dif.dec)
    );

    assign stFetch = state_q == ST_FETCH;
    assign stDone = state_q == ST_DONE;
    assign commit = clkEn && stDone && !dif.illegal;
    // Decode the incoming byte during fetch to know the cycle count early
    assign dif.opcode = stFetch ? opByte : opcode_q;

    assign progAddr = pc_q;
    assign peekData = peek_q;
    assign accValue = mem[`CAM_ADDR_ACC];
    assign zeroFlag = zero_q;
    assign carryFlag = carry_q;
    assign stackDepth = depth_q;
    assign instrDone = clkEn && stDone;
    assign illegalOp = clkEn && stDone && dif.illegal;
    assign modeNow = dif.mode;

    // Sequencer: fetch, wait out the cycle count, commit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_FETCH;
            cnt_q <= 3'h0;
        end else if (clkEn) begin
            case (state_q)
                ST_FETCH: begin
                    state_q <= (dif.cycles == `CAM_CYC_INH) ? ST_DONE : ST_RUN;
                    cnt_q <= 3'(dif.cycles - 3'h3);
                end
                ST_RUN: begin
                    if (cnt_q == 3'h0) begin
                        state_q <= ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_FETCH;
                end
                default: begin
                    state_q <= ST_FETCH;
                end
            endcase
        end
    end

    // Latch the instruction bytes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            opcode_q <= 8'h00;
            arg1_q <= 8'h00;
            arg2_q <= 8'h00;
        end else if (clkEn && stFetch) begin
            opcode_q <= opByte;
            arg1_q <= argByte1;
            arg2_q <= argByte2;
        end
    end

    // Operand address per mode
    always_comb begin
        opAddr = arg1_q;
        case (dif.mode)
            MODE_SDIR: opAddr = `CAM_ADDR_X | {6'h00, opcode_q[1:0]};
            MODE_IND: opAddr = opcode_q[`CAM_PTR_BIT] ? mem[`CAM_ADDR_Y]
                : mem[`CAM_ADDR_X];
            default: opAddr = arg1_q;
        endcase
    end

    assign operand = mem[opAddr];
    assign accVal = mem[`CAM_ADDR_ACC];
    assign bitNum = opcode_q[2:0];
    assign bitVal = operand[bitNum];
    assign bitMask = 8'h01 << bitNum;
    assign bitWritten = opcode_q[`CAM_SEL_BIT] ? (operand | bitMask)
        : (operand & ~bitMask);
    assign newAcc = (dif.op == OP_LOAD_IMM) ? arg1_q : operand;

    // Relative branch: test kind, direction, span
    always_comb begin
        case (opcode_q[6:5])
            2'h0: relTaken = carry_q;
            2'h1: relTaken = !carry_q;
            2'h2: relTaken = zero_q;
            default: relTaken = !zero_q;
        endcase
    end
    assign relTarget = opcode_q[`CAM_DIR_BIT] ? (pc_q - {8'h00, opcode_q[3:0]})
        : (pc_q + {8'h00, opcode_q[3:0]} + 12'h001);
    assign extTarget = {opcode_q[3:0], arg1_q};
    assign btbTarget = pc_q + 12'h001 + {{4{arg2_q[7]}}, arg2_q};

    assign spNext = (sp_q == SP_LAST) ? 3'h0 : sp_q + 3'h1;
    assign spPrev = (sp_q == 3'h0) ? SP_LAST : sp_q - 3'h1;

    always_comb begin
        nextPc = pc_q + {10'h000, dif.len};
        if (!dif.illegal) begin
            case (dif.op)
                OP_JR: begin
                    if (relTaken) begin
                        nextPc = relTarget;
                    end
                end
                OP_LONG_GO, OP_CALL: nextPc = extTarget;
                OP_BTB: begin
                    if (bitVal == opcode_q[`CAM_SEL_BIT]) begin
                        nextPc = btbTarget;
                    end
                end
                OP_RET: begin
                    if (depth_q != 3'h0) begin
                        nextPc = stack[spPrev];
                    end
                end
                default: nextPc = pc_q + {10'h000, dif.len};
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_q <= `CAM_PC_RESET;
        end else if (clkEn && stDone) begin
            pc_q <= nextPc;
        end
    end

    // Flags
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            zero_q <= 1'b0;
            carry_q <= 1'b0;
        end else if (commit) begin
            case (dif.op)
                OP_LOAD, OP_LOAD_IMM: zero_q <= newAcc == 8'h00;
                OP_STORE: zero_q <= accVal == 8'h00;
                OP_BIT_WRITE: carry_q <= bitVal;
                OP_BTB: carry_q <= bitVal;
                default: begin
                end
            endcase
        end
    end

    // Return stack, oldest entry overwritten past the last level
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sp_q <= 3'h0;
            depth_q <= 3'h0;
            for (int i = 0; i < STACK_LEVELS; i++) begin
                stack[i] <= `CAM_PC_RESET;
            end
        end else if (commit) begin
            if (dif.op == OP_CALL) begin
                stack[sp_q] <= pc_q + {10'h000, `CAM_LEN_TWO};
                sp_q <= spNext;
                if (depth_q != SP_FULL) begin
                    depth_q <= depth_q + 3'h1;
                end
            end else if (dif.op == OP_RET && depth_q != 3'h0) begin
                sp_q <= spPrev;
                depth_q <= depth_q - 3'h1;
            end
        end
    end

    // Data space: accumulator, working registers, RAM
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= `CAM_MEM_RESET;
            end
        end else if (commit) begin
            case (dif.op)
                OP_LOAD, OP_LOAD_IMM: mem[`CAM_ADDR_ACC] <= newAcc;
                OP_STORE: mem[opAddr] <= accVal;
                OP_LOAD_IMM_REG: mem[arg1_q] <= arg2_q;
                OP_BIT_WRITE: mem[opAddr] <= bitWritten;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            peek_q <= 8'h00;
        end else if (clkEn) begin
            peek_q <= mem[peekAddr];
        end
    end

    // Checking helpers: enabled cycles since fetch
    logic [2:0] instrCyc_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            instrCyc_q <= 3'h0;
        end else if (clkEn) begin
            instrCyc_q <= stFetch ? 3'h1 : instrCyc_q + 3'h1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_bit_commit;
        commit && dif.op == OP_BIT_WRITE;
    endsequence
    sequence s_btb_taken;
        commit && dif.op == OP_BTB && bitVal == opcode_q[`CAM_SEL_BIT];
    endsequence
    sequence s_short_fetch;
        stFetch && clkEn && dif.cycles == `CAM_CYC_INH;
    endsequence

    a_bit_carry:
        assert property (s_bit_commit |=> carry_q == $past(bitVal)
            && mem[$past(opAddr)][$past(bitNum)] == $past(opcode_q[3]))
        else $error("bit write did not load carry or bit");
    a_btb_carry:
        assert property (commit && dif.op == OP_BTB |=> carry_q == $past(bitVal))
        else $error("tested bit not shifted into carry");
    a_btb_branch:
        assert property (s_btb_taken |=> pc_q == $past(btbTarget))
        else $error("bit test branch went to wrong target");
    a_rel_window:
        assert property (commit && dif.op == OP_JR && relTaken
            |=> 12'(pc_q - $past(pc_q) + 12'h00F) <= 12'h01F)
        else $error("relative branch outside its span");
    a_ext_target:
        assert property (commit && (dif.op == OP_LONG_GO || dif.op == OP_CALL)
            |=> pc_q == {$past(opcode_q[3:0]), $past(arg1_q)})
        else $error("extended target wrong");
    a_ldst_cycles:
        assert property (commit && (dif.op == OP_LOAD || dif.op == OP_STORE)
            |-> instrCyc_q == 3'h3 ##1 $stable(carry_q))
        else $error("load or store not four cycles or carry moved");
    a_ldi_flags:
        assert property (commit && dif.op == OP_LOAD_IMM_REG
            |-> instrCyc_q == 3'h3 ##1 $stable(zero_q) && $stable(carry_q))
        else $error("register immediate load disturbed flags or timing");
    a_short_done:
        assert property (s_short_fetch |=> stDone)
        else $error("two-cycle instruction did not finish");
    a_step_len:
        assert property (commit && (dif.op == OP_LOAD || dif.op == OP_STORE
            || dif.op == OP_NOP) |=> pc_q == 12'($past(pc_q) + $past(dif.len)))
        else $error("program counter did not step past instruction");
    a_stack_bound:
        assert property (depth_q <= SP_FULL)
        else $error("stack depth beyond six");
    a_short_addr:
        assert property (stDone && dif.mode == MODE_SDIR
            |-> opAddr >= `CAM_ADDR_X && opAddr <= `CAM_ADDR_W)
        else $error("short direct address outside working registers");
endmodule

// ### test/cam_core_addr_bench.sv
/*
 * Self-checking bench of the addressing-mode core: feeds program bytes,
 * runs each instruction group and compares pc, flags, stack and data.
 * Assumes cam_pkg and the core design files are compiled before it.
 */
`timescale 1ns/1ps
module cam_core_addr_bench;
    import cam_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic clkEn = 1'b1;
    logic [7:0] opByte = 8'h00;
    logic [7:0] argByte1 = 8'h00;
    logic [7:0] argByte2 = 8'h00;
    logic [7:0] peekAddr = 8'h00;
    logic [11:0] progAddr;
    logic [7:0] peekData;
    logic [7:0] accValue;
    logic zeroFlag;
    logic carryFlag;
    logic [2:0] stackDepth;
    logic instrDone;
    logic illegalOp;
    cam_mode_t modeNow;
    int mismatches = 0;
    int samplesChecked = 0;
    int holdLeft = 0;
    logic [11:0] pc = 12'h000;

    cam_core_addr #(.STACK_LEVELS(6)) dut_u (
        .clk(clk), .resetn(resetn), .clkEn(clkEn), .opByte(opByte),
        .argByte1(argByte1), .argByte2(argByte2), .peekAddr(peekAddr),
        .progAddr(progAddr), .peekData(peekData), .accValue(accValue),
        .zeroFlag(zeroFlag), .carryFlag(carryFlag), .stackDepth(stackDepth),
        .instrDone(instrDone), .illegalOp(illegalOp), .modeNow(modeNow)
    );

    always #10 clk = ~clk;

    task automatic check_value(input logic [11:0] seen, input logic [11:0] expected);
        samplesChecked++;
        if (seen !== expected) begin
            mismatches++;
            $display("wrong value at %0t ns: seen %0h expected %0h", $time, seen, expected);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reference opcode map: bit 4 marks an invalid opcode
    function automatic logic [4:0] decode_ref(input logic [7:0] op);
        if (op[7] == 1'b0) return {1'b0, MODE_REL};
        case (op[7:4])
            4'h8, 4'h9: return {1'b0, MODE_EXT};
            4'hA: return {1'b0, MODE_BITD};
            4'hB: return {1'b0, MODE_BTB};
            4'hC, 4'hD: return (op[3:2] == 2'h0) ? {1'b0, MODE_SDIR} : {1'b1, MODE_INH};
            default: begin
                if (op[3:1] == 3'h0) return {1'b0, MODE_IND};
                if (op == 8'hE4 || op == 8'hE5) return {1'b0, MODE_DIR};
                if (op == 8'hF4 || op == 8'hF5) return {1'b0, MODE_IMM};
                if (op == 8'hE8 || op == 8'hE9) return {1'b0, MODE_INH};
                return {1'b1, MODE_INH};
            end
        endcase
    endfunction

    // Runs one instruction from its fetch negedge to the next fetch negedge
    task automatic exec(input logic [7:0] op, input logic [7:0] a1, input logic [7:0] a2,
                        input int cyc, input logic [11:0] nxt);
        logic [4:0] exp;
        logic en;
        int n;
        int guard;
        exp = decode_ref(op);
        n = 1;
        guard = 0;
        opByte = op;
        argByte1 = a1;
        argByte2 = a2;
        while (instrDone !== 1'b1 && guard < 40) begin
            if (n == 2 && holdLeft > 0) begin
                clkEn = 1'b0;
                holdLeft--;
                check_value(progAddr, pc);
            end else begin
                clkEn = 1'b1;
            end
            en = clkEn;
            @(negedge clk);
            guard++;
            if (en) n++;
        end
        check_value(n[11:0], cyc[11:0]);
        check_value(illegalOp, exp[4]);
        if (!exp[4]) check_value(modeNow, exp[3:0]);
        @(negedge clk);
        check_value(instrDone, 1'b0);
        check_value(progAddr, nxt);
        pc = nxt;
    endtask

    task automatic set_flags(input logic c, input logic z);
        exec(8'hF5, 8'h60, {7'h00, c}, 4, pc + 12'h3);
        exec(8'hA8, 8'h60, 8'h00, 4, pc + 12'h2);
        exec(8'hF4, {7'h00, ~z}, 8'h00, 4, pc + 12'h2);
        check_value({carryFlag, zeroFlag}, {c, z});
    endtask

    task automatic test_reset();
        check_value(progAddr, 12'h000);
        check_value({zeroFlag, carryFlag, instrDone}, 3'h0);
        check_value(stackDepth, 3'h0);
        check_value(accValue, 8'h00);
    endtask

    task automatic test_load_store();
        set_flags(1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            exec(8'hF5, 8'h80 | i[7:0], {i[3:0] + 4'h1, 4'h0}, 4, pc + 12'h3);
        end
        exec(8'hF5, 8'h10, 8'h77, 4, pc + 12'h3);
        exec(8'hF5, 8'h20, 8'h00, 4, pc + 12'h3);
        check_value({carryFlag, zeroFlag}, 2'h2);
        for (int i = 0; i < 4; i++) begin
            exec(8'hC0 | i[7:0], 8'h00, 8'h00, 4, pc + 12'h1);
            check_value(accValue, {i[3:0] + 4'h1, 4'h0});
        end
        exec(8'hF0, 8'h00, 8'h00, 4, pc + 12'h1);
        check_value({accValue, zeroFlag}, 9'h001);
        exec(8'hE0, 8'h00, 8'h00, 4, pc + 12'h1);
        check_value({accValue, zeroFlag}, 9'h0EE);
        exec(8'hE4, 8'hFF, 8'h00, 4, pc + 12'h2);
        check_value(accValue, 8'h77);
        exec(8'hD3, 8'h00, 8'h00, 4, pc + 12'h1);
        exec(8'hE5, 8'h90, 8'h00, 4, pc + 12'h2);
        exec(8'hF1, 8'h00, 8'h00, 4, pc + 12'h1);
        peekAddr = 8'h20;
        exec(8'hE8, 8'h00, 8'h00, 2, pc + 12'h1);
        check_value(peekData, 8'h77);
        exec(8'hF4, 8'h00, 8'h00, 4, pc + 12'h2);
        check_value({accValue, zeroFlag}, 9'h001);
        exec(8'hC3, 8'h00, 8'h00, 4, pc + 12'h1);
        check_value(accValue, 8'h77);
        exec(8'hF4, 8'h5A, 8'h00, 4, pc + 12'h2);
        holdLeft = 3;
        exec(8'hE4, 8'h90, 8'h00, 4, pc + 12'h2);
        check_value({accValue, zeroFlag, carryFlag}, 10'h1DD);
    endtask

    task automatic test_bits();
        exec(8'hF5, 8'h50, 8'h00, 4, pc + 12'h3);
        for (int b = 0; b < 8; b++) begin
            exec(8'hA8 | b[7:0], 8'h50, 8'h00, 4, pc + 12'h2);
            check_value(carryFlag, 1'b0);
            exec(8'hA8 | b[7:0], 8'h50, 8'h00, 4, pc + 12'h2);
            check_value(carryFlag, 1'b1);
        end
        exec(8'hE4, 8'h50, 8'h00, 4, pc + 12'h2);
        check_value(accValue, 8'hFF);
        for (int b = 0; b < 8; b++) begin
            exec(8'hA0 | b[7:0], 8'h50, 8'h00, 4, pc + 12'h2);
            check_value(carryFlag, 1'b1);
        end
        exec(8'hE4, 8'h50, 8'h00, 4, pc + 12'h2);
        check_value(accValue, 8'h00);
    endtask

    task automatic test_relative();
        logic [3:0] span;
        logic hit;
        logic [11:0] nxt;
        for (int f = 0; f < 4; f++) begin
            set_flags(f[1], f[0]);
            for (int k = 0; k < 4; k++) begin
                span = f[1] ? 4'hF : 4'h3;
                hit = (k == 0) ? f[1] : (k == 1) ? !f[1] : (k == 2) ? f[0] : !f[0];
                nxt = !hit ? pc + 12'h1 : f[0] ? pc - {8'h00, span} : pc + {8'h00, span} + 12'h1;
                exec({1'b0, k[1:0], f[0], span}, 8'h00, 8'h00, 2, nxt);
                check_value({carryFlag, zeroFlag}, f[1:0]);
            end
        end
    endtask

    task automatic test_jump_call();
        logic [11:0] ret [$];
        exec(8'hE9, 8'h00, 8'h00, 2, pc + 12'h1);
        check_value(stackDepth, 3'h0);
        exec(8'h8A, 8'h5C, 8'h00, 4, 12'hA5C);
        for (int i = 0; i < 7; i++) begin
            ret.push_back(pc + 12'h2);
            exec(8'h90 | i[7:0], 8'hC3, 8'h00, 4, {i[3:0], 8'hC3});
            check_value(stackDepth, (i < 6) ? i[2:0] + 3'h1 : 3'h6);
        end
        for (int i = 0; i < 6; i++) begin
            exec(8'hE9, 8'h00, 8'h00, 2, ret.pop_back());
            check_value(stackDepth, 3'h5 - i[2:0]);
        end
        exec(8'hE9, 8'h00, 8'h00, 2, pc + 12'h1);
    endtask

    task automatic test_bit_branch();
        logic [7:0] pat;
        logic [7:0] ee;
        logic tbit;
        pat = 8'hA5;
        exec(8'hF5, 8'h70, pat, 4, pc + 12'h3);
        for (int i = 0; i < 16; i++) begin
            tbit = pat[i[2:0]];
            ee = i[0] ? 8'h7F : 8'h80;
            exec({4'hB, i[3], i[2:0]}, 8'h70, ee, 5,
                 (tbit == i[3]) ? pc + 12'h1 + {{4{ee[7]}}, ee} : pc + 12'h3);
            check_value(carryFlag, tbit);
        end
        exec(8'hB8, 8'h71, 8'h05, 5, pc + 12'h3);
        check_value(carryFlag, 1'b0);
    endtask

    task automatic test_illegal();
        logic [7:0] bad [4];
        bad = '{8'hC4, 8'hE2, 8'hDC, 8'hFF};
        set_flags(1'b1, 1'b1);
        foreach (bad[i]) begin
            exec(bad[i], 8'h00, 8'h00, 2, pc + 12'h1);
            check_value({carryFlag, zeroFlag}, 2'h3);
        end
    endtask

    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        test_reset();
        resetn = 1'b1;
        test_load_store();
        test_bits();
        test_relative();
        test_jump_call();
        test_bit_branch();
        test_illegal();
        complete_run();
    end

    // Tests need under 500 cycles; 20000 leaves ample margin
    initial begin
        #400000;
        mismatches++;
        complete_run();
    end
endmodule
